// File: logic/cbtf_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the CAN bit timing and flag block.
  Assumes a 40 MHz system clock and byte addresses on a 32-bit AHB-Lite bus, one register per word.
*/
`ifndef CBTF_REGS_SVH
`define CBTF_REGS_SVH

// Byte offsets in the low address byte; upper address bits are decoded outside.
`define CBTF_OFF_FLAGS 8'h00
`define CBTF_OFF_CFG2 8'h04

// Interrupt flag word: bit positions and implemented bits.
`define CBTF_TX_BUFFER_FLAG 0
`define CBTF_RX_BUFFER_FLAG 1
`define CBTF_RX_OVERFLOW_FLAG 2
`define CBTF_FIFO_ALMOST_FULL_FLAG 3
`define CBTF_ERROR_EVENT_FLAG 5
`define CBTF_FLAGS_MASK 16'h002F
`define CBTF_FLAGS_RESET 16'h0000

// Bit timing configuration word two: field positions.
`define CBTF_WAKE_FILTER_BIT 14
`define CBTF_PH2_MSB 10
`define CBTF_PH2_LSB 8
`define CBTF_PH2_PROG_BIT 7
`define CBTF_TRIPLE_BIT 6
`define CBTF_PH1_MSB 5
`define CBTF_PH1_LSB 3
`define CBTF_PROP_MSB 2
`define CBTF_PROP_LSB 0
`define CBTF_CFG2_MASK 16'h47FF
`define CBTF_CFG2_RESET 16'h0000

// Information processing time in time quanta.
`define CBTF_IPT_TQ 4'h2

// Wake-up line filter: least low time in ns, and the clock period in ns.
`define CBTF_CLK_NS 25
`define CBTF_WAKE_FILT_NS 250
`define CBTF_WAKE_FILT_CYC ((`CBTF_WAKE_FILT_NS + `CBTF_CLK_NS - 1) / `CBTF_CLK_NS)

`endif

// File: logic/cbtf_pkg.sv
/*
  Types of the CAN bit timing and flag block.
  Assumes nothing of its surroundings.
*/
package cbtf_pkg;

	// Segment of the nominal bit time, one-hot.
	typedef enum logic [3:0] {
		CBTF_SYNC = 4'b0001,
		CBTF_PROP = 4'b0010,
		CBTF_PH1 = 4'b0100,
		CBTF_PH2 = 4'b1000
	} cbtf_seg_t;

	// Register selected by a bus address.
	typedef enum logic [1:0] {
		CBTF_REG_NONE = 2'b00,
		CBTF_REG_FLAGS = 2'b01,
		CBTF_REG_CFG2 = 2'b10
	} cbtf_reg_t;

endpackage

// File: logic/cbtf_timing_if.sv
/*
  Carrier between the register side and the bit timer.
  Assumes both ends run on the one system clock.
*/
`timescale 1ns/1ps
interface cbtf_timing_if;
	logic [2:0] propagation_length;
	logic [2:0] phase_one_length;
	logic [2:0] phase_two_length;
	logic phase_two_programmable_select;
	logic triple_sample;
	logic tq_tick;
	logic rx_bit;
	logic sample_strobe;
	logic sample_value;
	logic bit_start;
	cbtf_pkg::cbtf_seg_t segment;

	// Register side drives the settings and reads the results.
	modport ctrl (
		output propagation_length, phase_one_length, phase_two_length,
		output phase_two_programmable_select, triple_sample, tq_tick, rx_bit,
		input sample_strobe, sample_value, bit_start, segment
	);

	// Bit timer reads the settings.
	modport timer (
		input propagation_length, phase_one_length, phase_two_length,
		input phase_two_programmable_select, triple_sample, tq_tick, rx_bit,
		output sample_strobe, sample_value, bit_start, segment
	);
endinterface

// File: logic/cbtf_bit_timer.sv
/*
  Nominal bit time sequencer: sync, propagation, phase one and phase two, with sampling at the end of phase one.
  Assumes a time quantum tick from the baud prescaler and a receive line already synchronised to the clock.
*/
`timescale 1ns/1ps
`include "cbtf_regs.svh"
module cbtf_bit_timer (
	input wire logic clk_i, // System clock.
	input wire logic rst_n_i, // Asynchronous reset, active low.
	cbtf_timing_if.timer tif // Settings in, sample results out.
);
	cbtf_pkg::cbtf_seg_t seg_r;
	logic [3:0] qcnt_r;
	logic [1:0] hist_r;
	logic sample_strobe_r;
	logic sample_value_r;
	logic bit_start_r;
	logic [3:0] prop_len;
	logic [3:0] ph1_len;
	logic [3:0] ph2_len;
	logic [3:0] seg_len;
	logic seg_end;
	logic majority;

	// Every length is its code plus one quantum.
	assign prop_len = {1'b0, tif.propagation_length} + 4'h1;
	assign ph1_len = {1'b0, tif.phase_one_length} + 4'h1;

	// A free phase two follows its field; otherwise it is the longer of phase one and the processing time.
	always_comb begin
		if (tif.phase_two_programmable_select) begin
			ph2_len = {1'b0, tif.phase_two_length} + 4'h1;
		end else if (ph1_len > `CBTF_IPT_TQ) begin
			ph2_len = ph1_len;
		end else begin
			ph2_len = `CBTF_IPT_TQ;
		end
	end

	// Length of the segment now running; sync is always one quantum.
	always_comb begin
		case (seg_r)
			cbtf_pkg::CBTF_SYNC: seg_len = 4'h1;
			cbtf_pkg::CBTF_PROP: seg_len = prop_len;
			cbtf_pkg::CBTF_PH1: seg_len = ph1_len;
			cbtf_pkg::CBTF_PH2: seg_len = ph2_len;
			default: seg_len = 4'h1;
		endcase
	end

	assign seg_end = tif.tq_tick && (qcnt_r >= seg_len - 4'h1);

	// Sync, then propagation, phase one and phase two; settings changed mid-bit take effect at once.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			seg_r <= cbtf_pkg::CBTF_SYNC;
			qcnt_r <= 4'h0;
		end else if (seg_end) begin
			qcnt_r <= 4'h0;
			case (seg_r)
				cbtf_pkg::CBTF_SYNC: seg_r <= cbtf_pkg::CBTF_PROP;
				cbtf_pkg::CBTF_PROP: seg_r <= cbtf_pkg::CBTF_PH1;
				cbtf_pkg::CBTF_PH1: seg_r <= cbtf_pkg::CBTF_PH2;
				cbtf_pkg::CBTF_PH2: seg_r <= cbtf_pkg::CBTF_SYNC;
				default: seg_r <= cbtf_pkg::CBTF_SYNC;
			endcase
		end else if (tif.tq_tick) begin
			qcnt_r <= qcnt_r + 4'h1;
		end
	end

	// The line level at the two previous quanta, for triple sampling.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hist_r <= 2'b11;
		end else if (tif.tq_tick) begin
			hist_r <= {hist_r[0], tif.rx_bit};
		end
	end

	// Two of three wins; a short glitch near the sample point is thus outvoted.
	assign majority = (tif.rx_bit & hist_r[0]) | (tif.rx_bit & hist_r[1]) | (hist_r[0] & hist_r[1]);

	// Sample at the end of phase one and mark the start of each bit.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sample_strobe_r <= 1'b0;
			sample_value_r <= 1'b1;
			bit_start_r <= 1'b0;
		end else begin
			sample_strobe_r <= seg_end && (seg_r == cbtf_pkg::CBTF_PH1);
			bit_start_r <= seg_end && (seg_r == cbtf_pkg::CBTF_PH2);
			if (seg_end && (seg_r == cbtf_pkg::CBTF_PH1)) begin
				sample_value_r <= tif.triple_sample ? majority : tif.rx_bit;
			end
		end
	end

	assign tif.sample_strobe = sample_strobe_r;
	assign tif.sample_value = sample_value_r;
	assign tif.bit_start = bit_start_r;
	assign tif.segment = seg_r;
endmodule

// File: logic/cbtf_top.sv
/*
  CAN bit timing configuration and interrupt flag block, reached over AHB-Lite.
  Assumes a time quantum tick from the baud prescaler, event pulses from the frame engine on the same clock,
  and a receive pin from the transceiver, which is asynchronous to the clock.
*/
// Contract
// - With the wake filter select set, wake-up is seen through the line filter; otherwise the raw line is used.
// - Phase two lasts its 3-bit field at bits 10 to 8 plus one quantum, from 1 to 8 quanta.
// - Phase two select high uses the programmed length; low uses the longer of phase one and processing time.
// - Sampling select high takes three samples by majority at the sample point; low takes one.
// - Phase one lasts its 3-bit field at bits 5 to 3 plus one quantum, from 1 to 8 quanta.
// - Propagation lasts its 3-bit field at bits 2 to 0 plus one quantum, from 1 to 8 quanta.
`timescale 1ns/1ps
`include "cbtf_regs.svh"
module cbtf_top (
	input wire logic CLOCK_I, // System clock, 40 MHz.
	input wire logic RSTN_I, // Asynchronous reset, active low.
	input wire logic HSEL_I, // AHB slave select.
	input wire logic [31:0] HADDR_I, // AHB address.
	input wire logic [1:0] HTRANS_I, // AHB transfer type.
	input wire logic HWRITE_I, // AHB write, high for write.
	input wire logic [2:0] HSIZE_I, // AHB size, word only.
	input wire logic [31:0] HWDATA_I, // AHB write data.
	input wire logic HREADY_I, // AHB bus ready.
	output logic [31:0] HRDATA_O, // AHB read data.
	output logic HREADYOUT_O, // AHB slave ready.
	output logic HRESP_O, // AHB response, always OKAY.
	input wire logic TQ_TICK_I, // One pulse per time quantum.
	input wire logic CAN_RX_I, // Receive line from the transceiver.
	input wire logic TX_DONE_I, // Transmit buffer done, pulse.
	input wire logic RX_FILLED_I, // Receive buffer filled, pulse.
	input wire logic RX_OVERFLOW_I, // Receive buffer overflow, pulse.
	input wire logic FIFO_ALMOST_FULL_I, // FIFO almost full, pulse.
	input wire logic ERROR_EVENT_I, // Aggregated error event, pulse.
	output logic SAMPLE_STROBE_O, // Pulse at each sample point.
	output logic SAMPLE_BIT_O, // Sampled bus level.
	output logic BIT_START_O, // Pulse at the start of each bit.
	output logic WAKE_O // Pulse on wake-up activity.
);
	cbtf_timing_if tif ();

	logic rx_meta_r;
	logic rx_sync_r;
	logic [15:0] flags_r;
	logic [15:0] flags_nxt;
	logic [15:0] flag_set;
	logic [15:0] flag_clr;
	logic [15:0] cfg2_r;
	logic [15:0] cfg2_nxt;
	logic wr_pend_r;
	cbtf_pkg::cbtf_reg_t wr_sel_r;
	logic [31:0] hrdata_r;
	logic [31:0] hrdata_nxt;
	logic addr_phase;
	cbtf_pkg::cbtf_reg_t rd_sel;
	logic filt_line_r;
	logic [7:0] filt_cnt_r;
	logic wake_line;
	logic wake_prev_r;
	logic wake_r;

	// The implemented flag bits as a vector, so that the generate loop can pick single bits of it.
	localparam logic [15:0] flags_mask = `CBTF_FLAGS_MASK;

	// Decodes a bus address to the register it selects; used for both reads and writes.
	function automatic cbtf_pkg::cbtf_reg_t reg_decode(input logic [31:0] addr);
		cbtf_pkg::cbtf_reg_t sel;
		sel = cbtf_pkg::CBTF_REG_NONE;
		if (addr[7:0] == `CBTF_OFF_FLAGS) begin
			sel = cbtf_pkg::CBTF_REG_FLAGS;
		end else if (addr[7:0] == `CBTF_OFF_CFG2) begin
			sel = cbtf_pkg::CBTF_REG_CFG2;
		end
		return sel;
	endfunction

	// The receive pin is asynchronous; only the second stage is read anywhere.
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rx_meta_r <= 1'b1;
			rx_sync_r <= 1'b1;
		end else begin
			rx_meta_r <= CAN_RX_I;
			rx_sync_r <= rx_meta_r;
		end
	end

	// An address phase is taken when this slave is selected, the bus is ready and the transfer is non-sequential or sequential.
	assign addr_phase = HSEL_I && HREADY_I && HTRANS_I[1];
	assign rd_sel = reg_decode(HADDR_I);

	// Write data arrive one cycle after the address, so the address phase is held for that cycle.
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			wr_pend_r <= 1'b0;
			wr_sel_r <= cbtf_pkg::CBTF_REG_NONE;
		end else if (HREADY_I) begin
			wr_pend_r <= addr_phase && HWRITE_I;
			wr_sel_r <= rd_sel;
		end
	end

	// Event pulses from the frame engine, each onto its own flag bit.
	always_comb begin
		flag_set = 16'h0000;
		flag_set[`CBTF_TX_BUFFER_FLAG] = TX_DONE_I;
		flag_set[`CBTF_RX_BUFFER_FLAG] = RX_FILLED_I;
		flag_set[`CBTF_RX_OVERFLOW_FLAG] = RX_OVERFLOW_I;
		flag_set[`CBTF_FIFO_ALMOST_FULL_FLAG] = FIFO_ALMOST_FULL_I;
		flag_set[`CBTF_ERROR_EVENT_FLAG] = ERROR_EVENT_I;
	end

	// Flags are clear-only: writing 0 to a bit clears it, writing 1 leaves it.
	assign flag_clr = (wr_pend_r && wr_sel_r == cbtf_pkg::CBTF_REG_FLAGS) ? ~HWDATA_I[15:0] : 16'h0000;

	// A set in the same cycle as its clear wins, so no event is lost.
	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : gen_flag
			assign flags_nxt[g] = flags_mask[g] & (flag_set[g] | (flags_r[g] & ~flag_clr[g]));
		end
	endgenerate

	// Flag word storage.
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			flags_r <= `CBTF_FLAGS_RESET;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// Configuration word two; unimplemented bits stay zero.
	assign cfg2_nxt = (wr_pend_r && wr_sel_r == cbtf_pkg::CBTF_REG_CFG2) ?
		(HWDATA_I[15:0] & `CBTF_CFG2_MASK) : cfg2_r;

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			cfg2_r <= `CBTF_CFG2_RESET;
		end else begin
			cfg2_r <= cfg2_nxt;
		end
	end

	// Reads see the next values, so a read right after a write returns the written data.
	always_comb begin
		hrdata_nxt = 32'h0000_0000;
		case (rd_sel)
			cbtf_pkg::CBTF_REG_FLAGS: hrdata_nxt = {16'h0000, flags_nxt};
			cbtf_pkg::CBTF_REG_CFG2: hrdata_nxt = {16'h0000, cfg2_nxt};
			default: hrdata_nxt = 32'h0000_0000;
		endcase
	end

	// Read data are loaded at the address phase and stand through the data phase.
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			hrdata_r <= 32'h0000_0000;
		end else if (addr_phase && !HWRITE_I) begin
			hrdata_r <= hrdata_nxt;
		end
	end

	// The slave never stalls or errors; the size is not checked, because only whole words are moved.
	assign HRDATA_O = hrdata_r;
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O = 1'b0;

	// Settings to the bit timer, straight from the configuration word.
	assign tif.propagation_length = cfg2_r[`CBTF_PROP_MSB:`CBTF_PROP_LSB];
	assign tif.phase_one_length = cfg2_r[`CBTF_PH1_MSB:`CBTF_PH1_LSB];
	assign tif.phase_two_length = cfg2_r[`CBTF_PH2_MSB:`CBTF_PH2_LSB];
	assign tif.phase_two_programmable_select = cfg2_r[`CBTF_PH2_PROG_BIT];
	assign tif.triple_sample = cfg2_r[`CBTF_TRIPLE_BIT];
	assign tif.tq_tick = TQ_TICK_I;
	assign tif.rx_bit = rx_sync_r;

	// Segment sequencer and sampler, fed through the carrier interface.
	cbtf_bit_timer u_bit_timer (
		.clk_i(CLOCK_I),
		.rst_n_i(RSTN_I),
		.tif(tif)
	);

	// Timer results go straight to the pins; they are already registered inside the timer.
	assign SAMPLE_STROBE_O = tif.sample_strobe;
	assign SAMPLE_BIT_O = tif.sample_value;
	assign BIT_START_O = tif.bit_start;

	// Line filter: the filtered level follows the line only after it has held for the full filter time.
	// This rejects short glitches that would otherwise wake the node, at the cost of a fixed delay.
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			filt_line_r <= 1'b1;
			filt_cnt_r <= 8'h00;
		end else if (rx_sync_r == filt_line_r) begin
			filt_cnt_r <= 8'h00;
		end else if (filt_cnt_r >= 8'(`CBTF_WAKE_FILT_CYC - 1)) begin
			filt_line_r <= rx_sync_r;
			filt_cnt_r <= 8'h00;
		end else begin
			filt_cnt_r <= filt_cnt_r + 8'h01;
		end
	end

	// Wake-up activity is a falling edge of the chosen line.
	// The edge detector idles high, as the recessive line does, so that no false wake follows reset.
	assign wake_line = cfg2_r[`CBTF_WAKE_FILTER_BIT] ? filt_line_r : rx_sync_r;

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			wake_prev_r <= 1'b1;
			wake_r <= 1'b0;
		end else begin
			wake_prev_r <= wake_line;
			wake_r <= wake_prev_r && !wake_line;
		end
	end

	assign WAKE_O = wake_r;
endmodule

// File: test/cbtf_monitor.sv
/*
  Port checks for the CAN bit timing and flag block.
  Assumes one clock domain and the register map of the shared header.
*/
`timescale 1ns/1ps
`include "cbtf_regs.svh"
module cbtf_monitor (
	input wire logic CLOCK_I, // Clock.
	input wire logic RSTN_I, // Reset, active low.
	input wire logic HSEL_I, // Select.
	input wire logic [31:0] HADDR_I, // Address.
	input wire logic [1:0] HTRANS_I, // Transfer type.
	input wire logic HWRITE_I, // Write.
	input wire logic [31:0] HWDATA_I, // Write data.
	input wire logic HREADY_I, // Bus ready.
	input wire logic [31:0] HRDATA_O, // Read data.
	input wire logic TQ_TICK_I, // Quantum tick.
	input wire logic SAMPLE_STROBE_O, // Sample point.
	input wire logic SAMPLE_BIT_O, // Sampled level.
	input wire logic BIT_START_O, // Bit start.
	input wire logic WAKE_O // Wake pulse.
);
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RSTN_I);
	// Decoded address phases; the idle cycle between matches a master that does not pipeline.
	wire logic take = HSEL_I && HREADY_I && HTRANS_I[1];
	wire logic wr_cfg = take && HWRITE_I && (HADDR_I[7:0] == `CBTF_OFF_CFG2);
	wire logic rd_cfg = take && !HWRITE_I && (HADDR_I[7:0] == `CBTF_OFF_CFG2);
	sequence s_readback; wr_cfg ##1 !take ##1 rd_cfg; endsequence
	property p_readback; s_readback |=> HRDATA_O == {16'h0000, $past(HWDATA_I[15:0], 2) & `CBTF_CFG2_MASK}; endproperty
	property p_high_zero; HRDATA_O[31:15] == 17'h0_0000; endproperty
	property p_strobe_tick; SAMPLE_STROBE_O |-> $past(TQ_TICK_I); endproperty
	property p_start_tick; BIT_START_O |-> $past(TQ_TICK_I) && !SAMPLE_STROBE_O; endproperty
	property p_strobe_gap; SAMPLE_STROBE_O |=> !SAMPLE_STROBE_O [*3]; endproperty
	property p_start_gap; BIT_START_O |=> !BIT_START_O [*3]; endproperty
	property p_bit_hold; (SAMPLE_BIT_O != $past(SAMPLE_BIT_O)) |-> SAMPLE_STROBE_O; endproperty
	property p_wake_pulse; WAKE_O |=> !WAKE_O; endproperty
	a_readback: assert property (p_readback) else $error("config readback wrong");
	a_high_zero: assert property (p_high_zero) else $error("unused read bits set");
	a_strobe_tick: assert property (p_strobe_tick) else $error("strobe without tick");
	a_start_tick: assert property (p_start_tick) else $error("bit start misplaced");
	a_strobe_gap: assert property (p_strobe_gap) else $error("strobes too close");
	a_start_gap: assert property (p_start_gap) else $error("bit starts too close");
	a_bit_hold: assert property (p_bit_hold) else $error("sample moved off strobe");
	a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
endmodule
bind cbtf_top cbtf_monitor cbtf_monitor_inst (.CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .HSEL_I(HSEL_I),
	.HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
	.HRDATA_O(HRDATA_O), .TQ_TICK_I(TQ_TICK_I), .SAMPLE_STROBE_O(SAMPLE_STROBE_O),
	.SAMPLE_BIT_O(SAMPLE_BIT_O), .BIT_START_O(BIT_START_O), .WAKE_O(WAKE_O));

// File: test/cbtf_can_node.sv
/*
  Other nodes behind the transceiver: recessive unless told to drive a dominant pulse.
  Assumes requests arrive on the system clock.
*/
`timescale 1ns/1ps
module cbtf_can_node (
	input wire logic clk_i, // Clock.
	input wire logic rst_n_i, // Reset, active low.
	input wire logic start_i, // Begin a dominant pulse.
	input wire logic [4:0] len_i, // Pulse length in clocks.
	output logic rx_o // Bus level.
);
	logic [4:0] left_r;
	// The bus falls back to recessive once no node drives it.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			left_r <= 5'h00;
		end else if (start_i) begin
			left_r <= len_i;
		end else if (left_r != 5'h00) begin
			left_r <= left_r - 5'h01;
		end
	end
	assign rx_o = (left_r == 5'h00);
endmodule

// File: test/test_can_bit_timing_and_flags.sv
/*
  Self-checking bench for the CAN bit timing and flag block.
  Assumes a quantum tick every four clocks, made here.
*/
`timescale 1ns/1ps
`include "cbtf_regs.svh"
module test_can_bit_timing_and_flags;
	logic clk, rst_n, hsel, hwrite, tick, dom_go;
	logic [1:0] htrans, tq_cnt;
	logic [31:0] haddr, hwdata, rdata;
	logic [4:0] ev, dom_len;
	wire logic [31:0] hrdata;
	wire logic hready, hresp, can_rx, strobe, sbit, bstart, wake;
	int err_count, n_checks;

	// Only whole words are moved, so the size is fixed.
	cbtf_top cbtf_top_inst (.CLOCK_I(clk), .RSTN_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
		.HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
		.HREADYOUT_O(hready), .HRESP_O(hresp), .TQ_TICK_I(tick), .CAN_RX_I(can_rx), .TX_DONE_I(ev[0]),
		.RX_FILLED_I(ev[1]), .RX_OVERFLOW_I(ev[2]), .FIFO_ALMOST_FULL_I(ev[3]), .ERROR_EVENT_I(ev[4]),
		.SAMPLE_STROBE_O(strobe), .SAMPLE_BIT_O(sbit), .BIT_START_O(bstart), .WAKE_O(wake));
	// Far node on the receive line.
	cbtf_can_node cbtf_can_node_inst (.clk_i(clk), .rst_n_i(rst_n), .start_i(dom_go), .len_i(dom_len), .rx_o(can_rx));

	// Clock of 25 ns.
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	// One tick in four clocks, so every quantum lasts four cycles.
	always @(posedge clk) begin
		if (!rst_n) begin
			tq_cnt <= 2'h0;
			tick <= 1'h0;
		end else begin
			tq_cnt <= tq_cnt + 2'h1;
			tick <= (tq_cnt == 2'h3);
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One single transfer; the wait ends only on ready, never on a fixed count.
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'h1;
		hwrite <= wr;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		do @(posedge clk); while (hready !== 1'h1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'h1);
		rdata = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'h0, a, 32'h0);
		chk(rdata, exp);
	endtask
	// Counts clocks until the strobe (which set) or the bit start shows; each edge sees what the last one launched.
	task wait_ev(input logic which, output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((which ? strobe : bstart) !== 1'h1 && n < 400);
		if ((which ? strobe : bstart) !== 1'h1) begin
			err_count++;
			$display("[ERR] t=%0t wait got=%h exp=%h", $time, n, 400);
		end
	endtask

	task t_regs;
		rd_chk(`CBTF_OFF_CFG2, 32'h0);
		ahb(1'h1, `CBTF_OFF_CFG2, 32'hFFFF_FFFF);
		rd_chk(`CBTF_OFF_CFG2, 32'h0000_47FF);
		ahb(1'h1, 8'h08, 32'hFFFF_FFFF);
		rd_chk(8'h08, 32'h0);
		$display("test regs done");
	endtask
	// Each event sets only its own flag; writing ones keeps it, zero clears it.
	task t_flags;
		int pos;
		for (int i = 0; i < 5; i++) begin
			pos = (i == 4) ? 5 : i;
			@(posedge clk);
			ev <= 5'h01 << i;
			@(posedge clk);
			rd_chk(`CBTF_OFF_FLAGS, 32'h1 << pos);
			ev <= 5'h00;
			ahb(1'h1, `CBTF_OFF_FLAGS, 32'hFFFF_FFFF);
			rd_chk(`CBTF_OFF_FLAGS, 32'h1 << pos);
			ahb(1'h1, `CBTF_OFF_FLAGS, 32'h0);
			rd_chk(`CBTF_OFF_FLAGS, 32'h0);
		end
		// An event that stands during the clearing write must survive it.
		ev <= 5'h01;
		ahb(1'h1, `CBTF_OFF_FLAGS, 32'h0);
		ev <= 5'h00;
		rd_chk(`CBTF_OFF_FLAGS, 32'h1);
		$display("test flags done");
	endtask
	// Segment lengths at both ends of each field, and both phase two modes.
	task t_timing;
		logic [15:0] cfg [5];
		int s1, st, bt, n, c1, c2;
		cfg = '{16'h0080, 16'h07FF, 16'h0028, 16'h0000, 16'h0291};
		foreach (cfg[i]) begin
			s1 = cfg[i][5:3] + 1;
			st = 2 + cfg[i][2:0] + s1;
			bt = st + (cfg[i][7] ? cfg[i][10:8] + 1 : ((s1 > `CBTF_IPT_TQ) ? s1 : `CBTF_IPT_TQ));
			ahb(1'h1, `CBTF_OFF_CFG2, {16'h0000, cfg[i]});
			wait_ev(1'h0, n);
			wait_ev(1'h1, c1);
			chk(c1, 4 * st);
			wait_ev(1'h0, c2);
			chk(c1 + c2, 4 * bt);
		end
		$display("test timing done");
	endtask
	// A dominant glitch on the last of three samples only; a single sample sees it, a vote does not.
	task t_sample;
		int n;
		for (int m = 0; m < 2; m++) begin
			ahb(1'h1, `CBTF_OFF_CFG2, 32'h0000_0080 | (m << 6));
			wait_ev(1'h0, n);
			repeat (6) @(posedge clk);
			dom_len <= 5'h03;
			dom_go <= 1'h1;
			@(posedge clk);
			dom_go <= 1'h0;
			wait_ev(1'h1, n);
			chk({31'h0, sbit}, m);
		end
		$display("test sample done");
	endtask
	// Short pulse wakes through the raw path only; a long one passes the filter.
	task t_wake;
		logic [4:0] lens [3];
		int cnt;
		lens = '{5'h03, 5'h03, 5'h0E};
		for (int k = 0; k < 3; k++) begin
			ahb(1'h1, `CBTF_OFF_CFG2, (k == 0) ? 32'h0 : 32'h0000_4000);
			dom_len <= lens[k];
			dom_go <= 1'h1;
			@(posedge clk);
			dom_go <= 1'h0;
			cnt = 0;
			repeat (40) begin
				@(posedge clk);
				cnt += (wake === 1'h1);
			end
			chk(cnt, (k == 1) ? 0 : 1);
		end
		$display("test wake done");
	endtask

	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Main sequence.
	initial begin
		{rst_n, hsel, hwrite, dom_go, htrans} = '0;
		{haddr, hwdata, ev, dom_len} = '0;
		err_count = 0;
		n_checks = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		t_regs;
		t_flags;
		t_timing;
		t_sample;
		t_wake;
		tally_and_finish;
	end
	// The run needs under a thousand clocks; a hang is cut well beyond that.
	initial begin
		repeat (10000) @(posedge clk);
		err_count++;
		$display("[ERR] t=%0t timeout got=%h exp=%h", $time, 32'h0, 32'h1);
		tally_and_finish;
	end
endmodule
